// ==== hw/vlt_toggle_unit.sv ====
/*
 * Ramp-direction toggle, vector length calculator and short-vector
 * detector of a vector position generator front end.
 * Assumes controller and converter-card signals arrive asynchronously
 * to mclk and that displacement data are held for the whole ramp.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Initialise pulse clears the toggle
// - Toggle flips on draw-start trailing edge
// - Direction low when reset, high when set
// - External state output is inverted toggle
// - State output feeds controller and converters
// - True and complement feed timing logic
// - Length is larger plus half smaller
// - Eleven-bit X and Y displacement inputs
// - X-major adder with X carry, 12 bits
// - Y-major adder with Y carry, 12 bits
// - Comparator steers length multiplexer
// - Length output is twelve bits wide
// - Three charge modes: short, long, move
// - Bits five to eleven clear enable attenuation
// - Bits two to four give attenuation code
// - Attenuation scales intensity with length
// - Move instruction blocks attenuation
module vlt_toggle_unit
    import vlt_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic display_init_pulse,
    input wire logic draw_start_pulse,
    input wire logic vector_not_move_select,
    input wire logic beam_unblank,
    input wire logic [DISP_W-1:0] x_displacement_bits,
    input wire logic [DISP_W-1:0] y_displacement_bits,
    input wire logic x_adder_carry_in,
    input wire logic y_adder_carry_in,
    output logic ramp_dir,
    output logic toggle_state_out_n,
    output logic toggle_true,
    output logic toggle_comp,
    output logic [LEN_W-1:0] x_major_range_sum,
    output logic [LEN_W-1:0] y_major_range_sum,
    output logic [LEN_W-1:0] vector_length_n,
    output logic x_is_larger,
    output logic atten_enable,
    output logic [CODE_W-1:0] atten_code,
    output logic [1:0] charge_mode,
    output logic [DRIVE_W-1:0] beam_intensity_drive
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // All pins but mclk and reset cross into mclk through two flops; the first stage
    // is read only by the second.
    localparam int SYNC_W = 4 + 2 * DISP_W + 2;
    localparam logic [SYNC_W-1:0] SYNC_RST = '0;

    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;

    assign pins = {display_init_pulse, draw_start_pulse, vector_not_move_select,
                   beam_unblank, x_displacement_bits, y_displacement_bits,
                   x_adder_carry_in, y_adder_carry_in};

    always_ff @(posedge mclk) begin
        if (reset) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    logic init_s;
    logic start_s;
    logic vec_sel_s;
    logic unblank_s;
    logic [DISP_W-1:0] x_disp_s;
    logic [DISP_W-1:0] y_disp_s;
    logic x_carry_s;
    logic y_carry_s;

    assign {init_s, start_s, vec_sel_s, unblank_s, x_disp_s, y_disp_s,
            x_carry_s, y_carry_s} = sync_q;

    // ==========================================================
    // Ramp-direction toggle
    // ==========================================================
    logic start_prev_q;
    logic start_fall;
    logic toggle_q;

    always_ff @(posedge mclk) begin
        if (reset) begin
            start_prev_q <= 1'h0;
        end else begin
            start_prev_q <= start_s;
        end
    end

    // Trailing edge, so a long strobe still flips the state once
    assign start_fall = start_prev_q & ~start_s;

    always_ff @(posedge mclk) begin
        if (reset) begin
            toggle_q <= TOGGLE_RST;
        end else if (init_s) begin
            toggle_q <= TOGGLE_RST;
        end else if (start_fall) begin
            toggle_q <= ~toggle_q;
        end
    end

    assign ramp_dir = toggle_q;
    // One net fans out to the controller and both converter cards
    assign toggle_state_out_n = ~toggle_q;
    assign toggle_true = toggle_q;
    assign toggle_comp = ~toggle_q;

    // ==========================================================
    // Length calculator
    // ==========================================================
    vlt_len_if lb ();

    assign lb.x_disp = x_disp_s;
    assign lb.y_disp = y_disp_s;
    assign lb.x_carry = x_carry_s;
    assign lb.y_carry = y_carry_s;

    vlt_length_calc u_calc (
        .lb(lb.calc)
    );

    logic [LEN_W-1:0] length;

    assign length = lb.length;
    assign x_major_range_sum = lb.x_major_sum;
    assign y_major_range_sum = lb.y_major_sum;
    assign x_is_larger = lb.x_larger;
    // Driven from the synchroniser flops only, so it holds while inputs hold
    assign vector_length_n = ~length;

    // ==========================================================
    // Short-vector detector and charge mode
    // ==========================================================
    logic short_len;
    vlt_mode_t mode;

    assign short_len = (length[LEN_W-1:SHORT_LSB] == '0);
    // A blanked move must never dim the beam
    assign atten_enable = short_len & vec_sel_s;
    // Bit five is known clear here, so three bits suffice
    assign atten_code = atten_enable ? length[CODE_LSB+CODE_W-1:CODE_LSB] : '0;

    always_comb begin
        if (!vec_sel_s) begin
            mode = MODE_MOVE;
        end else if (short_len) begin
            mode = MODE_CONST_TIME;
        end else begin
            mode = MODE_CONST_VEL;
        end
    end

    assign charge_mode = mode;

    // ==========================================================
    // Intensity drive
    // ==========================================================
    // Short vectors dwell a fixed time, so shorter ones get less drive
    logic [DRIVE_W-1:0] drive_d;
    logic [DRIVE_W-1:0] drive_q;

    always_comb begin
        if (!unblank_s) begin
            drive_d = DRIVE_OFF;
        end else if (atten_enable) begin
            drive_d = {1'b0, atten_code} + DRIVE_STEP;
        end else begin
            drive_d = DRIVE_FULL;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            drive_q <= DRIVE_OFF;
        end else begin
            drive_q <= drive_d;
        end
    end

    assign beam_intensity_drive = drive_q;

    // ==========================================================
    // Checks
    // ==========================================================
    logic [LEN_W-1:0] exp_len;

    always_comb begin
        if (x_disp_s > y_disp_s) begin
            exp_len = {1'b0, x_disp_s} + {2'b00, y_disp_s[DISP_W-1:1]} + {11'h000, x_carry_s};
        end else begin
            exp_len = {1'b0, y_disp_s} + {2'b00, x_disp_s[DISP_W-1:1]} + {11'h000, y_carry_s};
        end
    end

    chk_init_clears: assert property (@(posedge mclk) disable iff (reset)
        init_s |=> !toggle_q)
        else $error("toggle not cleared by initialise");

    chk_toggle_flips: assert property (@(posedge mclk) disable iff (reset)
        (start_fall && !init_s) |=> (toggle_q != $past(toggle_q)))
        else $error("toggle did not flip on draw start");

    chk_toggle_holds: assert property (@(posedge mclk) disable iff (reset)
        (!start_fall && !init_s) |=> $stable(toggle_q))
        else $error("toggle changed without draw start");

    chk_state_polarity: assert property (@(posedge mclk) disable iff (reset)
        $rose(ramp_dir) |-> $fell(toggle_state_out_n) && toggle_true && !toggle_comp)
        else $error("state outputs disagree with direction");

    chk_length_value: assert property (@(posedge mclk) disable iff (reset)
        vector_length_n == ~exp_len)
        else $error("length not larger plus half smaller");

    chk_length_stable: assert property (@(posedge mclk) disable iff (reset)
        $stable(sync_q) |-> $stable(vector_length_n) && $stable(atten_enable))
        else $error("length moved while inputs held");

    chk_short_detect: assert property (@(posedge mclk) disable iff (reset)
        (vec_sel_s && exp_len < 12'h020) |-> atten_enable && mode == MODE_CONST_TIME)
        else $error("short vector not detected");

    chk_move_inhibit: assert property (@(posedge mclk) disable iff (reset)
        !vec_sel_s |-> !atten_enable && mode == MODE_MOVE)
        else $error("move enabled attenuation");

    chk_atten_code: assert property (@(posedge mclk) disable iff (reset)
        atten_enable |-> atten_code == exp_len[4:2])
        else $error("attenuation code wrong");

    chk_drive_level: assert property (@(posedge mclk) disable iff (reset)
        (unblank_s && vec_sel_s && exp_len >= 12'h020) |=> beam_intensity_drive == 4'hF)
        else $error("long vector not at full drive");

    // ==========================================================
    // Datapath, direction and drive checks
    // ==========================================================
    chk_x_sum: assert property (@(posedge mclk) disable iff (reset)
        x_major_range_sum == {1'b0, x_disp_s} + {2'b00, y_disp_s[DISP_W-1:1]} + {11'h000, x_carry_s})
        else $error("x-major sum wrong");

    chk_y_sum: assert property (@(posedge mclk) disable iff (reset)
        y_major_range_sum == {1'b0, y_disp_s} + {2'b00, x_disp_s[DISP_W-1:1]} + {11'h000, y_carry_s})
        else $error("y-major sum wrong");

    chk_steer_select: assert property (@(posedge mclk) disable iff (reset)
        (x_disp_s > y_disp_s) |-> x_is_larger && vector_length_n == ~x_major_range_sum)
        else $error("larger x did not select x-major sum");

    chk_tie_select: assert property (@(posedge mclk) disable iff (reset)
        (x_disp_s <= y_disp_s) |-> !x_is_larger && vector_length_n == ~y_major_range_sum)
        else $error("y-major sum not selected");

    chk_long_mode: assert property (@(posedge mclk) disable iff (reset)
        (vec_sel_s && exp_len >= 12'h020) |-> !atten_enable && mode == MODE_CONST_VEL)
        else $error("long vector not in constant velocity");

    chk_code_idle: assert property (@(posedge mclk) disable iff (reset)
        !atten_enable |-> atten_code == 3'h0)
        else $error("attenuation code without enable");

    chk_blank_drive: assert property (@(posedge mclk) disable iff (reset)
        !unblank_s |=> beam_intensity_drive == DRIVE_OFF)
        else $error("beam driven while blanked");

    chk_short_drive: assert property (@(posedge mclk) disable iff (reset)
        (unblank_s && vec_sel_s && exp_len < 12'h020) |=>
        beam_intensity_drive == {1'b0, $past(exp_len[4:2])} + DRIVE_STEP)
        else $error("short vector drive not scaled");

    chk_move_drive: assert property (@(posedge mclk) disable iff (reset)
        (unblank_s && !vec_sel_s) |=> beam_intensity_drive == DRIVE_FULL)
        else $error("move drive attenuated");

    chk_init_priority: assert property (@(posedge mclk) disable iff (reset)
        (init_s && start_fall) |=> !toggle_q)
        else $error("draw start beat initialise");

    chk_dir_rising: assert property (@(posedge mclk) disable iff (reset)
        (start_fall && !init_s && !toggle_q) |=> ramp_dir && !toggle_state_out_n)
        else $error("ramp did not turn rising");

    chk_dir_falling: assert property (@(posedge mclk) disable iff (reset)
        $fell(ramp_dir) |-> $rose(toggle_state_out_n) && !toggle_true && toggle_comp)
        else $error("state outputs disagree on falling ramp");
endmodule
`default_nettype wire

// ==== hw/vlt_pkg.sv ====
/*
 * Constants and types shared by the vector length toggle unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vlt_pkg;
    // ==========================================================
    // Widths
    // ==========================================================
    localparam int DISP_W = 11;
    localparam int LEN_W = 12;
    localparam int DRIVE_W = 4;
    localparam int CODE_W = 3;

    // ==========================================================
    // Field positions in the length word
    // ==========================================================
    localparam int SHORT_LSB = 5;
    localparam int CODE_LSB = 2;

    // ==========================================================
    // Reset values and levels
    // ==========================================================
    localparam logic TOGGLE_RST = 1'h0;
    localparam logic [DRIVE_W-1:0] DRIVE_FULL = 4'hF;
    localparam logic [DRIVE_W-1:0] DRIVE_OFF = 4'h0;
    localparam logic [DRIVE_W-1:0] DRIVE_STEP = 4'h1;

    // ==========================================================
    // Charge-rate modes
    // ==========================================================
    typedef enum logic [1:0] {
        MODE_CONST_TIME = 2'b00,
        MODE_CONST_VEL = 2'b01,
        MODE_MOVE = 2'b10
    } vlt_mode_t;
endpackage

// ==== hw/vlt_len_if.sv ====
/*
 * Bundle between the toggle unit and its length calculator.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface vlt_len_if;
    import vlt_pkg::*;
    logic [DISP_W-1:0] x_disp;
    logic [DISP_W-1:0] y_disp;
    logic x_carry;
    logic y_carry;
    logic [LEN_W-1:0] x_major_sum;
    logic [LEN_W-1:0] y_major_sum;
    logic x_larger;
    logic [LEN_W-1:0] length;

    modport calc (
        input x_disp,
        input y_disp,
        input x_carry,
        input y_carry,
        output x_major_sum,
        output y_major_sum,
        output x_larger,
        output length
    );
    modport user (
        output x_disp,
        output y_disp,
        output x_carry,
        output y_carry,
        input x_major_sum,
        input y_major_sum,
        input x_larger,
        input length
    );
endinterface
`default_nettype wire

// ==== hw/vlt_length_calc.sv ====
/*
 * Vector length approximation: larger displacement plus half the smaller.
 * Assumes displacement inputs held steady for the ramp period.
 */
`timescale 1ns/1ps
`default_nettype none
module vlt_length_calc
    import vlt_pkg::*;
(
    vlt_len_if.calc lb
);
    // ==========================================================
    // Halved operands
    // ==========================================================
    // Dropping the low bit keeps both adders the same 12-bit width
    logic [LEN_W-1:0] x_full;
    logic [LEN_W-1:0] y_full;
    logic [LEN_W-1:0] x_half;
    logic [LEN_W-1:0] y_half;

    assign x_full = {1'b0, lb.x_disp};
    assign y_full = {1'b0, lb.y_disp};
    assign x_half = {2'b00, lb.x_disp[DISP_W-1:1]};
    assign y_half = {2'b00, lb.y_disp[DISP_W-1:1]};

    // ==========================================================
    // Adders, comparator and select
    // ==========================================================
    assign lb.x_major_sum = x_full + y_half + {{(LEN_W-1){1'b0}}, lb.x_carry};
    assign lb.y_major_sum = y_full + x_half + {{(LEN_W-1){1'b0}}, lb.y_carry};
    assign lb.x_larger = (lb.x_disp > lb.y_disp);
    assign lb.length = lb.x_larger ? lb.x_major_sum : lb.y_major_sum;
endmodule
`default_nettype wire

// ==== sim/vlt_conv_model.sv ====
/*
 * Behavioural model of the two position converter cards.
 * Assumes the move-busy output stays inactive and one clock for all.
 */
`timescale 1ns/1ps
`default_nettype none
module vlt_conv_model
    import vlt_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic toggle_state_out_n,
    input wire logic x_position_store_strobe,
    input wire logic y_position_store_strobe,
    input wire logic end_of_ramp_load_pulse,
    input wire logic [DISP_W-1:0] new_x,
    input wire logic [DISP_W-1:0] new_y,
    output logic [DISP_W-1:0] x_disp,
    output logic [DISP_W-1:0] y_disp
);
    // ==========================================================
    // First and second stage position storage
    // ==========================================================
    logic [DISP_W-1:0] ax_q, ay_q, bx_q, by_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ax_q <= '0;
            ay_q <= '0;
            bx_q <= '0;
            by_q <= '0;
        end else begin
            // Strobes during a ramp are ignored, as on the real cards
            if (toggle_state_out_n && x_position_store_strobe) begin
                ax_q <= new_x;
            end
            if (toggle_state_out_n && y_position_store_strobe) begin
                ay_q <= new_y;
            end
            if (!toggle_state_out_n && end_of_ramp_load_pulse) begin
                bx_q <= ax_q;
                by_q <= ay_q;
            end
        end
    end
    assign x_disp = (ax_q > bx_q) ? ax_q - bx_q : bx_q - ax_q;
    assign y_disp = (ay_q > by_q) ? ay_q - by_q : by_q - ay_q;
endmodule
`default_nettype wire

// ==== sim/vector_length_toggle_unit_tb.sv ====
/*
 * Self-checking bench for the vector length toggle unit.
 * Assumes the converter model of this folder and the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module vector_length_toggle_unit_tb;
    import vlt_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic mclk, reset, init_p, start_p, sel, unblank, cx, cy, stx, sty, rend;
    logic [DISP_W-1:0] new_x, new_y, x_disp, y_disp, ox, oy;
    logic ramp_dir, tso_n, t_true, t_comp, x_larger, atten;
    logic [LEN_W-1:0] xs, ys, len_n;
    logic [CODE_W-1:0] code;
    logic [1:0] mode;
    logic [DRIVE_W-1:0] drive;
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'hB412C61D;
    logic [10:0] tx[6] = '{11'h010, 11'h02F, 11'h04F, 11'h14F, 11'h7FF, 11'h7F0};
    logic [10:0] ty[6] = '{11'h004, 11'h004, 11'h004, 11'h104, 11'h7FF, 11'h7F0};
    logic [3:0] tf[6] = '{4'h3, 4'h2, 4'h3, 4'h3, 4'hF, 4'h1};

    vlt_toggle_unit vlt_toggle_unit_inst (.mclk(mclk), .reset(reset), .display_init_pulse(init_p),
        .draw_start_pulse(start_p), .vector_not_move_select(sel), .beam_unblank(unblank),
        .x_displacement_bits(x_disp), .y_displacement_bits(y_disp), .x_adder_carry_in(cx),
        .y_adder_carry_in(cy), .ramp_dir(ramp_dir), .toggle_state_out_n(tso_n), .toggle_true(t_true),
        .toggle_comp(t_comp), .x_major_range_sum(xs), .y_major_range_sum(ys), .vector_length_n(len_n),
        .x_is_larger(x_larger), .atten_enable(atten), .atten_code(code), .charge_mode(mode),
        .beam_intensity_drive(drive));
    vlt_conv_model vlt_conv_model_inst (.mclk(mclk), .reset(reset), .toggle_state_out_n(tso_n),
        .x_position_store_strobe(stx), .y_position_store_strobe(sty), .end_of_ramp_load_pulse(rend),
        .new_x(new_x), .new_y(new_y), .x_disp(x_disp), .y_disp(y_disp));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk_tog(input logic t);
        check(ramp_dir, t);
        check(tso_n, !t);
        check({t_true, t_comp}, {t, !t});
    endtask
    // Held three cycles high and four low so the synchronisers see both edges
    task automatic draw;
        start_p = 1;
        cyc(3);
        start_p = 0;
        cyc(4);
    endtask
    task automatic clear_tog;
        init_p = 1;
        cyc(2);
        init_p = 0;
        cyc(4);
    endtask
    task automatic vec(input logic [10:0] nx, input logic [10:0] ny, input logic [3:0] f);
        logic [10:0] dx, dy;
        logic [11:0] sx, sy, len;
        logic sh, at;
        new_x = nx; // Position is presented before its strobe
        new_y = ny;
        cyc(1);
        stx = 1;
        sty = 1;
        cyc(1);
        stx = 0;
        sty = 0;
        {cx, cy, sel, unblank} = f;
        cyc(5);
        dx = nx > ox ? nx - ox : ox - nx;
        dy = ny > oy ? ny - oy : oy - ny;
        sx = 12'(dx) + 12'(dy >> 1) + 12'(cx);
        sy = 12'(dy) + 12'(dx >> 1) + 12'(cy);
        len = dx > dy ? sx : sy;
        sh = len[11:5] == 7'h00;
        at = sh && sel;
        check(xs, sx);
        check(ys, sy);
        check(x_larger, dx > dy);
        check(len_n, ~len);
        check(atten, at);
        check(code, at ? len[4:2] : 3'h0);
        check(mode, !sel ? 2'h2 : sh ? 2'h0 : 2'h1);
        check(drive, !unblank ? 4'h0 : at ? 4'(len[4:2]) + 4'h1 : 4'hF);
        draw;
        chk_tog(1);
        rend = 1;
        cyc(1);
        rend = 0;
        ox = nx;
        oy = ny;
        clear_tog;
        chk_tog(0);
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    // ==========================================================
    initial begin
        mclk = 0;
        forever #12.5 mclk = ~mclk;
    end
    initial begin
        repeat (8000) @(posedge mclk);
        n_fail++;
        report_and_stop;
    end
    initial begin
        {reset, init_p, start_p, sel, unblank, cx, cy, stx, sty, rend} = 10'h200;
        new_x = '0;
        new_y = '0;
        ox = '0;
        oy = '0;
        cyc(3);
        chk_tog(0);
        check(len_n, 12'hFFF);
        check({mode, drive}, 6'h20);
        reset = 0;
        cyc(2);
        for (int i = 0; i < 4; i++) begin
            draw;
            chk_tog(i % 2 == 0);
        end
        start_p = 1;
        cyc(3);
        start_p = 0;
        clear_tog; // Trailing edge meets initialise, which must win
        chk_tog(0);
        draw;
        clear_tog;
        chk_tog(0);
        for (int i = 0; i < 6; i++) begin
            vec(tx[i], ty[i], tf[i]);
        end
        // Random displacements, carries and modes
        for (int i = 0; i < 30; i++) begin
            vec(11'($random(seed)), 11'($random(seed)), 4'($random(seed)));
        end
        report_and_stop;
    end
endmodule
`default_nettype wire
